/* hdl/hgei_defines.svh */
`ifndef HGEI_DEFINES_SVH
`define HGEI_DEFINES_SVH

// host-side register offsets
`define HGEI_OFS_SELECT   8'h28
`define HGEI_OFS_READBACK 8'h29
`define HGEI_OFS_MAILBOX  8'h2a
`define HGEI_OFS_FW_STAT  8'h30
`define HGEI_OFS_FW_EN    8'h31
`define HGEI_OFS_PWR      8'h32
`define HGEI_OFS_INTR     8'h34

// reset values
`define HGEI_RST_SELECT   6'h00
`define HGEI_RST_MAILBOX  8'hff
`define HGEI_RST_FW       8'h00
`define HGEI_RST_BYTE     8'h00

// mailbox idle marker written back by the controller
`define HGEI_MBOX_IDLE    8'hff

// select value that picks no pin, and the select value of the last pin
`define HGEI_SEL_HOLE     31
`define HGEI_SEL_LAST     57

// field positions
`define HGEI_PIN_BIT      0
`define HGEI_PWR_BIT      7
`define HGEI_LATCH_BIT    0
`define HGEI_LIVE_BIT     1
`define HGEI_SEL_MSB      5

// cycles after system reset before chassis edges count; four fill the
// chain, one more lets the previous-level tracker catch up, else a high
// switch at release would look like an edge and set the kept latch
`define HGEI_SETTLE_CYC   3'd5

`endif

/* hdl/hgei_pkg.sv */
package hgei_pkg;
  // one host register byte
  typedef logic [7:0] hgei_byte_t;
  // pin select field
  typedef logic [5:0] hgei_sel_t;
endpackage

/* hdl/hgei_sync.sv */
`timescale 1ns/1ps
// three-stage input synchroniser; output moves when stages two and
// three agree, which filters a one-cycle glitch out of stage two
module hgei_sync
  import hgei_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);
  logic [WIDTH-1:0] s1_q;   // metastability catcher, read by s2 only
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] sync_d;

  // per bit: take the new level only once two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign sync_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sync_q[i];
  end

  // register the chain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      s1_q   <= async_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      sync_q <= sync_d;
    end
  end
endmodule

/* hdl/hgei_regs.sv */
`timescale 1ns/1ps
`include "hgei_defines.svh"
module hgei_regs
  import hgei_pkg::*;
#(
  parameter int PIN_COUNT = 58,
  parameter int EN1_W     = 32
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   vbat_por_b,
  input  wire logic                   clk_en,
  input  wire hgei_byte_t             host_addr,
  input  wire logic                   host_wr_stb,
  input  wire logic                   host_rd_stb,
  input  wire hgei_byte_t             host_wdata,
  output hgei_byte_t                  host_rdata_q,
  output logic                        host_rvalid_q,
  input  wire logic [PIN_COUNT-1:0]   gpio_pins,
  input  wire logic [EN1_W-1:0]       ec_access_en1,
  input  wire logic [PIN_COUNT-EN1_W-1:0] ec_access_en2,
  input  wire logic                   ec_mbox_wr,
  input  wire hgei_byte_t             ec_mbox_wdata,
  input  wire logic                   ec_req_clr,
  input  wire logic                   ec_req_irq_en,
  input  wire hgei_byte_t             ec_fw_set,
  input  wire logic                   ec_fw_clr_dis,
  input  wire logic                   supply_good_in,
  input  wire logic                   sleep_s3_n,
  input  wire logic                   chassis_pin,
  output hgei_sel_t                   pin_select_q,
  output hgei_byte_t                  pin_write_mailbox_q,
  output logic                        pin_write_req_q,
  output logic                        ec_irq_q,
  output hgei_byte_t                  fw_event_status_q,
  output hgei_byte_t                  fw_event_enable_q,
  output logic                        fw_event_summary_q
);
  localparam int SW = PIN_COUNT + 3;   // pins plus supply, sleep and chassis pins
  logic [SW-1:0]        sync_all;      // synchronised pin levels
  logic [PIN_COUNT-1:0] pin_lvl;       // synchronised gpio pins
  logic                 supply_s;      // synchronised supply good
  logic                 sleep_s;       // synchronised sleep-s3
  logic                 chassis_s;     // synchronised chassis switch
  logic [PIN_COUNT-1:0] access_en;     // joined per-pin enables
  logic [PIN_COUNT-1:0] sel_hit;       // one-hot select decode
  logic                 pin_ok;        // selected pin exists, enabled
  logic                 pin_val;       // gated level of that pin
  // host strobes decoded per register
  logic wr_sel, wr_mbox, wr_fwst, wr_fwen, wr_intr;
  // host-visible group, loaded by system reset (mailbox set to ff, rest cleared)
  hgei_sel_t  pin_select_d;
  hgei_byte_t pin_write_mailbox_d;
  logic       pin_write_req_d;
  logic       ec_irq_d;
  hgei_byte_t fw_event_status_d;
  hgei_byte_t fw_event_enable_d;
  logic       fw_event_summary_d;
  hgei_byte_t host_rdata_d;
  logic       host_rvalid_d;
  // battery-backed group, loaded by battery reset only (state cleared, latch set)
  logic last_supply_state_q, last_supply_state_d;
  logic chassis_latch_q,     chassis_latch_d;
  // edge trackers, cleared by system reset
  logic       supply_prev_q, supply_prev_d;
  logic       chassis_prev_q, chassis_prev_d;
  logic [2:0] settle_q, settle_d;      // arms chassis edge detect
  logic       supply_fall;
  logic       chassis_edge;
  // all outside levels pass the three-stage chain
  hgei_sync #(.WIDTH(SW)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in ({chassis_pin, sleep_s3_n, supply_good_in, gpio_pins}),
    .sync_q   (sync_all)
  );

  assign pin_lvl   = sync_all[PIN_COUNT-1:0];
  assign supply_s  = sync_all[PIN_COUNT];
  assign sleep_s   = sync_all[PIN_COUNT+1];
  assign chassis_s = sync_all[PIN_COUNT+2];
  // first word covers selects 0-31, second 32 up
  assign access_en = {ec_access_en2, ec_access_en1};
  // decode: select value equals pin index, 31 is a hole
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sel
    if (i == `HGEI_SEL_HOLE) begin : g_hole
      assign sel_hit[i] = 1'b0;
    end else begin : g_pin
      assign sel_hit[i] = (pin_select_q == 6'(i)) &&
                          access_en[i];
    end
  end
  // values above the last pin never match a decode bit
  assign pin_ok  = |sel_hit;
  assign pin_val = |(sel_hit & pin_lvl);
  // host write decode
  assign wr_sel  = host_wr_stb && (host_addr == `HGEI_OFS_SELECT);
  assign wr_mbox = host_wr_stb && (host_addr == `HGEI_OFS_MAILBOX);
  assign wr_fwst = host_wr_stb && (host_addr == `HGEI_OFS_FW_STAT);
  assign wr_fwen = host_wr_stb && (host_addr == `HGEI_OFS_FW_EN);
  assign wr_intr = host_wr_stb && (host_addr == `HGEI_OFS_INTR);
  assign supply_fall  = supply_prev_q && !supply_s;
  assign chassis_edge = (settle_q == `HGEI_SETTLE_CYC) &&
                        (chassis_prev_q != chassis_s);
  // next state of the host-visible group
  always_comb begin
    pin_select_d        = pin_select_q;
    pin_write_mailbox_d = pin_write_mailbox_q;
    pin_write_req_d     = pin_write_req_q;
    fw_event_status_d   = fw_event_status_q;
    fw_event_enable_d   = fw_event_enable_q;
    // host writes land even when the mailbox is busy; the host is
    // expected to wait for the idle marker
    if (wr_sel) begin
      pin_select_d = host_wdata[`HGEI_SEL_MSB:0];
    end
    // controller idle marker; a host write in the same cycle wins
    if (ec_mbox_wr) begin
      pin_write_mailbox_d = ec_mbox_wdata;
    end
    if (wr_mbox) begin
      pin_write_mailbox_d = host_wdata;
    end
    // request flag: a set in the clearing cycle is kept
    if (ec_req_clr) begin
      pin_write_req_d = 1'b0;
    end
    if (wr_mbox && pin_ok) begin
      pin_write_req_d = 1'b1;
    end
    ec_irq_d = pin_write_req_d && ec_req_irq_en;
    // write-one-to-clear unless the controller blocks it
    if (wr_fwst && !ec_fw_clr_dis) begin
      fw_event_status_d = fw_event_status_d & ~host_wdata;
    end
    fw_event_status_d = fw_event_status_d | ec_fw_set;
    if (wr_fwen) begin
      fw_event_enable_d = host_wdata;
    end
    fw_event_summary_d = |(fw_event_status_d &
                           fw_event_enable_d);
    // read mux; reserved bits and unmapped offsets read zero
    host_rvalid_d = host_rd_stb;
    host_rdata_d  = `HGEI_RST_BYTE;
    if (host_rd_stb) begin
      unique case (host_addr)
        `HGEI_OFS_SELECT:   host_rdata_d[`HGEI_SEL_MSB:0] = pin_select_q;
        `HGEI_OFS_READBACK: host_rdata_d[`HGEI_PIN_BIT] = pin_val;
        `HGEI_OFS_MAILBOX:  host_rdata_d = pin_write_mailbox_q;
        `HGEI_OFS_FW_STAT:  host_rdata_d = fw_event_status_q;
        `HGEI_OFS_FW_EN:    host_rdata_d = fw_event_enable_q;
        `HGEI_OFS_PWR: begin
          host_rdata_d[`HGEI_PWR_BIT] = last_supply_state_q;
        end
        `HGEI_OFS_INTR: begin
          host_rdata_d[`HGEI_LIVE_BIT]  = chassis_s;
          host_rdata_d[`HGEI_LATCH_BIT] = chassis_latch_q;
        end
        default:            host_rdata_d = `HGEI_RST_BYTE;
      endcase
    end
  end

  // register the host-visible group
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_select_q        <= `HGEI_RST_SELECT;
      pin_write_mailbox_q <= `HGEI_RST_MAILBOX;
      pin_write_req_q     <= 1'b0;
      ec_irq_q            <= 1'b0;
      fw_event_status_q   <= `HGEI_RST_FW;
      fw_event_enable_q   <= `HGEI_RST_FW;
      fw_event_summary_q  <= 1'b0;
      host_rdata_q        <= `HGEI_RST_BYTE;
      host_rvalid_q       <= 1'b0;
    end else if (clk_en) begin
      pin_select_q        <= pin_select_d;
      pin_write_mailbox_q <= pin_write_mailbox_d;
      pin_write_req_q     <= pin_write_req_d;
      ec_irq_q            <= ec_irq_d;
      fw_event_status_q   <= fw_event_status_d;
      fw_event_enable_q   <= fw_event_enable_d;
      fw_event_summary_q  <= fw_event_summary_d;
      host_rdata_q        <= host_rdata_d;
      host_rvalid_q       <= host_rvalid_d;
    end
  end

  // next state of the edge trackers
  always_comb begin
    supply_prev_d  = supply_s;
    chassis_prev_d = chassis_s;
    // wait for the chain to fill so the reset level is no edge
    settle_d = (settle_q == `HGEI_SETTLE_CYC) ? settle_q
                                              : settle_q + 3'd1;
  end

  // register the edge trackers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_prev_q  <= 1'b0;
      chassis_prev_q <= 1'b0;
      settle_q       <= 3'd0;
    end else if (clk_en) begin
      supply_prev_q  <= supply_prev_d;
      chassis_prev_q <= chassis_prev_d;
      settle_q       <= settle_d;
    end
  end

  // next state of the battery-backed group
  always_comb begin
    last_supply_state_d = last_supply_state_q;
    chassis_latch_d     = chassis_latch_q;
    if (supply_fall) begin
      last_supply_state_d = sleep_s;
    end
    // write of one clears, zero ignored, new edge wins
    if (wr_intr && host_wdata[`HGEI_LATCH_BIT]) begin
      chassis_latch_d = 1'b0;
    end
    if (chassis_edge) begin
      chassis_latch_d = 1'b1;
    end
  end

  // battery reset only; system reset leaves these alone
  always_ff @(posedge sys_clk or negedge vbat_por_b) begin
    if (!vbat_por_b) begin
      last_supply_state_q <= 1'b0;
      chassis_latch_q     <= 1'b1;
    end else if (clk_en) begin
      last_supply_state_q <= last_supply_state_d;
      chassis_latch_q     <= chassis_latch_d;
    end
  end

  // checks
  sum_flag_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    $past(clk_en) |-> fw_event_summary_q ==
      |(fw_event_status_q & fw_event_enable_q))
    else $error("event summary does not match status and enable");

  host_clear_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && wr_fwst && !ec_fw_clr_dis && ec_fw_set == 8'h00
    |=> (fw_event_status_q & $past(host_wdata)) == 8'h00)
    else $error("write of one did not clear event bit");

  clear_block_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && wr_fwst && ec_fw_clr_dis
    |=> fw_event_status_q ==
      ($past(fw_event_status_q) | $past(ec_fw_set)))
    else $error("blocked clear still changed event bits");

  ctrl_set_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && ec_fw_set != 8'h00
    |=> (fw_event_status_q & $past(ec_fw_set)) == $past(ec_fw_set))
    else $error("controller set of event bit lost");

  mbox_req_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && wr_mbox && pin_ok |=> pin_write_req_q ##0
      (ec_irq_q == ec_req_irq_en || !$past(ec_req_irq_en)))
    else $error("enabled mailbox write raised no request");

  mbox_noreq_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && wr_mbox && !pin_ok && !pin_write_req_q
    |=> !pin_write_req_q)
    else $error("disabled pin write raised a request");

  read_pin_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && host_rd_stb && host_addr == `HGEI_OFS_READBACK
    |=> host_rvalid_q && host_rdata_q == {7'h00, $past(pin_val)})
    else $error("readback byte wrong");

  supply_cap_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && supply_fall |=> last_supply_state_q == $past(sleep_s))
    else $error("supply fall did not capture sleep level");

  intr_set_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && chassis_edge |=> chassis_latch_q)
    else $error("chassis edge did not set latch");

  intr_keep_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    chassis_latch_q && !(clk_en && wr_intr &&
      host_wdata[`HGEI_LATCH_BIT]) |=> chassis_latch_q)
    else $error("latch cleared without a write of one");

  live_level_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    clk_en && host_rd_stb && host_addr == `HGEI_OFS_INTR
    |=> host_rdata_q[`HGEI_LIVE_BIT] == $past(chassis_s))
    else $error("intrusion read shows wrong live level");

  mbox_cycle_c: cover property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    wr_mbox && pin_ok ##[1:20] ec_mbox_wr);
  fw_event_c: cover property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    fw_event_summary_q ##[1:20] !fw_event_summary_q);
  supply_fall_c: cover property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    supply_fall && sleep_s);
  intrusion_c: cover property (@(posedge sys_clk)
    disable iff (!rst_b || !vbat_por_b)
    chassis_edge ##[1:20] !chassis_latch_q);
endmodule

/* verification/hgei_ec_model.sv */
`timescale 1ns/1ps
// firmware stand-in: answers a pin-write request after a set delay
module hgei_ec_model
  import hgei_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       req,
  input  wire hgei_sel_t  sel,
  input  wire hgei_byte_t mbox,
  input  wire logic [3:0] delay,
  output logic            ec_mbox_wr,
  output hgei_byte_t      ec_mbox_wdata,
  output logic            ec_req_clr,
  output logic            pin_upd,
  output hgei_sel_t       pin_idx,
  output logic            pin_val
);
  int cnt; // cycles left in the service routine

  // drives on the falling edge, like the bench
  always @(negedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt = 0;
      ec_mbox_wr = 1'b0;
      ec_req_clr = 1'b0;
      pin_upd = 1'b0;
      pin_idx = 6'h00;
      pin_val = 1'b0;
      ec_mbox_wdata = 8'h00;
    end else begin
      // idle data bus shows the inverse of ff, never a stale copy
      ec_mbox_wr = 1'b0;
      ec_req_clr = 1'b0;
      pin_upd = 1'b0;
      ec_mbox_wdata = 8'h00;
      if (cnt > 0) begin
        cnt = cnt - 1;
        // pin first: host must not see idle before the pin moved
        if (cnt == 1) begin
          pin_upd = 1'b1;
          pin_idx = sel;
          pin_val = mbox[0];
        end
        if (cnt == 0) begin
          ec_mbox_wr = 1'b1;
          ec_mbox_wdata = 8'hff;
          ec_req_clr = 1'b1;
        end
      end else if (req) begin
        cnt = 32'(delay) + 2;
      end
    end
  end
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
`include "hgei_defines.svh"
// host byte accesses against the register group, firmware modelled
module tb
  import hgei_pkg::*;
;
  logic        sys_clk = 1'b0; // 20 MHz
  logic        rst_b, vbat_por_b, host_wr_stb, host_rd_stb, host_rvalid_q;
  logic        clk_en = 1'b1; // low freezes the whole block
  hgei_byte_t  host_addr, host_wdata, host_rdata_q, ec_mbox_wdata;
  hgei_byte_t  ec_fw_set, mbox_q, stat_q, en_q;
  logic [57:0] gpio_lvl; // pin levels, index is select value
  logic [31:0] en1;
  logic [25:0] en2;
  logic        ec_mbox_wr, ec_req_clr, req_q, irq_q, irq_en, clr_dis;
  logic        supply_good, sleep_n, chassis, summary_q, pin_upd, pin_val;
  logic [3:0]  ec_delay; // firmware response time
  hgei_sel_t   sel_q, pin_idx;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #25 sys_clk = ~sys_clk;

  hgei_regs hgei_regs_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .vbat_por_b(vbat_por_b),
    .clk_en(clk_en), .host_addr(host_addr), .host_wr_stb(host_wr_stb),
    .host_rd_stb(host_rd_stb), .host_wdata(host_wdata),
    .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
    .gpio_pins(gpio_lvl), .ec_access_en1(en1), .ec_access_en2(en2),
    .ec_mbox_wr(ec_mbox_wr), .ec_mbox_wdata(ec_mbox_wdata),
    .ec_req_clr(ec_req_clr), .ec_req_irq_en(irq_en),
    .ec_fw_set(ec_fw_set), .ec_fw_clr_dis(clr_dis),
    .supply_good_in(supply_good), .sleep_s3_n(sleep_n),
    .chassis_pin(chassis), .pin_select_q(sel_q),
    .pin_write_mailbox_q(mbox_q), .pin_write_req_q(req_q),
    .ec_irq_q(irq_q), .fw_event_status_q(stat_q),
    .fw_event_enable_q(en_q), .fw_event_summary_q(summary_q)
  );

  hgei_ec_model hgei_ec_model_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .req(req_q), .sel(sel_q),
    .mbox(mbox_q), .delay(ec_delay), .ec_mbox_wr(ec_mbox_wr),
    .ec_mbox_wdata(ec_mbox_wdata), .ec_req_clr(ec_req_clr),
    .pin_upd(pin_upd), .pin_idx(pin_idx), .pin_val(pin_val)
  );

  // firmware pin drive lands on the board pins
  always @(posedge sys_clk) begin
    if (pin_upd)
      gpio_lvl[pin_idx] <= pin_val;
  end

  task automatic cmp8(string what, hgei_byte_t exp, hgei_byte_t got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpb(string what, logic exp, logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one-cycle write strobe, released a cycle later
  task automatic wr(hgei_byte_t a, hgei_byte_t d);
    @(negedge sys_clk);
    host_addr = a;
    host_wdata = d;
    host_wr_stb = 1'b1;
    @(negedge sys_clk);
    host_wr_stb = 1'b0;
  endtask

  // data only counts when the valid pulse is up
  task automatic rd(hgei_byte_t a, output hgei_byte_t v);
    @(negedge sys_clk);
    host_addr = a;
    host_rd_stb = 1'b1;
    @(negedge sys_clk);
    host_rd_stb = 1'b0;
    v = (host_rvalid_q === 1'b1) ? host_rdata_q : 8'hxx;
  endtask

  task automatic chk(hgei_byte_t a, hgei_byte_t exp, string what);
    hgei_byte_t v;
    rd(a, v);
    cmp8(what, exp, v);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // poll for the idle marker; a hung firmware ends the run
  task automatic wait_idle();
    hgei_byte_t v;
    v = 8'h00;
    for (int n = 0; n < 40 && v !== 8'hff; n++)
      rd(`HGEI_OFS_MAILBOX, v);
    if (v !== 8'hff) begin
      cmp8("mailbox idle", 8'hff, v);
      print_verdict();
    end
  endtask

  task automatic sys_reset();
    @(negedge sys_clk);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(8);
  endtask

  initial begin
    hgei_byte_t exp;
    {rst_b, vbat_por_b, host_wr_stb, host_rd_stb} = 4'h0;
    {host_addr, host_wdata, ec_fw_set} = 24'h000000;
    gpio_lvl = 58'h1aa_d3c3_c5a5_f00f;
    {en1, en2, irq_en, clr_dis, chassis} = 61'h0;
    {supply_good, sleep_n} = 2'h3;
    ec_delay = 4'h9;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    vbat_por_b = 1'b1;
    cyc(8);
    chk(`HGEI_OFS_SELECT, 8'h00, "select");
    chk(`HGEI_OFS_MAILBOX, 8'hff, "mailbox");
    chk(`HGEI_OFS_FW_STAT, 8'h00, "fw status");
    chk(`HGEI_OFS_PWR, 8'h00, "supply state");
    chk(`HGEI_OFS_INTR, 8'h01, "intrusion");
    chk(8'h2b, 8'h00, "unmapped");
    $display("test reset done");
    // alternate enables, flipped on the second pass; 31 stays empty
    for (int p = 0; p < 2; p++) begin
      en1 = p ? 32'haaaa_aaaa : 32'h5555_5555;
      en2 = p ? 26'h2aa_aaaa : 26'h155_5555;
      for (int s = 0; s < 64; s++) begin
        wr(`HGEI_OFS_SELECT, 8'(s));
        exp = (s < 58 && s != 31 && s % 2 == p) ? {7'h00, gpio_lvl[s]} : 0;
        chk(`HGEI_OFS_READBACK, exp, "readback");
        chk(`HGEI_OFS_SELECT, 8'(s), "select back");
        cmp8("select port", 8'(s), {2'b00, sel_q});
      end
    end
    $display("test select done");
    en1 = 32'h0000_0020;
    wr(`HGEI_OFS_SELECT, 8'h05);
    for (int i = 0; i < 2; i++) begin
      irq_en = i[0];
      ec_delay = i ? 4'h0 : 4'h9;
      wr(`HGEI_OFS_MAILBOX, {7'h00, ~i[0]});
      cmpb("request", 1'b1, req_q);
      cmpb("ec irq", i[0], irq_q);
      wait_idle();
      cmpb("request clear", 1'b0, req_q);
      cmp8("mailbox port", 8'hff, mbox_q);
      cmpb("pin level", ~i[0], gpio_lvl[5]);
      cyc(5);
      chk(`HGEI_OFS_READBACK, {7'h00, ~i[0]}, "pin back");
    end
    // disabled pin, then the empty select with its enable bit set
    for (int j = 0; j < 2; j++) begin
      en1 = j ? 32'h8000_0000 : 32'h0000_0000;
      wr(`HGEI_OFS_SELECT, j ? 8'h1f : 8'h05);
      wr(`HGEI_OFS_MAILBOX, 8'h01);
      cmpb("refused request", 1'b0, req_q);
      chk(`HGEI_OFS_MAILBOX, 8'h01, "mailbox data");
      wr(`HGEI_OFS_MAILBOX, 8'hff);
    end
    $display("test mailbox done");
    @(negedge sys_clk);
    ec_fw_set = 8'h81;
    @(negedge sys_clk);
    ec_fw_set = 8'h00;
    chk(`HGEI_OFS_FW_STAT, 8'h81, "fw set");
    cmpb("summary off", 1'b0, summary_q);
    wr(`HGEI_OFS_FW_EN, 8'h01);
    cmpb("summary on", 1'b1, summary_q);
    clr_dis = 1'b1;
    wr(`HGEI_OFS_FW_STAT, 8'h01);
    chk(`HGEI_OFS_FW_STAT, 8'h81, "clear blocked");
    clr_dis = 1'b0;
    wr(`HGEI_OFS_FW_STAT, 8'h01);
    chk(`HGEI_OFS_FW_STAT, 8'h80, "clear one");
    cmpb("summary drop", 1'b0, summary_q);
    chk(`HGEI_OFS_FW_EN, 8'h01, "fw enable");
    cmp8("fw status port", 8'h80, stat_q);
    cmp8("fw enable port", 8'h01, en_q);
    // a write while the clock enable is low must not land
    clk_en = 1'b0;
    wr(`HGEI_OFS_FW_EN, 8'h55);
    clk_en = 1'b1;
    chk(`HGEI_OFS_FW_EN, 8'h01, "frozen enable");
    $display("test events done");
    for (int k = 0; k < 2; k++) begin
      sleep_n = k[0];
      cyc(6);
      supply_good = 1'b0;
      cyc(8);
      chk(`HGEI_OFS_PWR, {k[0], 7'h00}, "supply state");
      supply_good = 1'b1;
      cyc(6);
    end
    wr(`HGEI_OFS_PWR, 8'h00);
    sys_reset();
    chk(`HGEI_OFS_PWR, 8'h80, "state kept");
    $display("test supply done");
    wr(`HGEI_OFS_INTR, 8'hfe);
    chk(`HGEI_OFS_INTR, 8'h01, "write zero");
    wr(`HGEI_OFS_INTR, 8'h01);
    chk(`HGEI_OFS_INTR, 8'h00, "latch clear");
    for (int e = 0; e < 2; e++) begin
      chassis = ~e[0];
      cyc(6);
      chk(`HGEI_OFS_INTR, {6'h00, ~e[0], 1'b1}, "edge");
      wr(`HGEI_OFS_INTR, 8'h01);
      chk(`HGEI_OFS_INTR, {6'h00, ~e[0], 1'b0}, "live");
    end
    chassis = 1'b1;
    cyc(6);
    sys_reset();
    chk(`HGEI_OFS_INTR, 8'h03, "kept latch");
    wr(`HGEI_OFS_INTR, 8'h01);
    // a high switch at system reset release is no edge
    sys_reset();
    chk(`HGEI_OFS_INTR, 8'h02, "kept clear");
    @(negedge sys_clk);
    vbat_por_b = 1'b0;
    cyc(2);
    vbat_por_b = 1'b1;
    cyc(2);
    chk(`HGEI_OFS_INTR, 8'h03, "battery set");
    chk(`HGEI_OFS_PWR, 8'h00, "battery clear");
    $display("test intrusion done");
    print_verdict();
  end
endmodule
